// ---- design/qdb_pkg.sv ----
package qdb_pkg;

    // ------------------------------------------------------------------
    // data organisation
    // ------------------------------------------------------------------
    localparam int LANE_W     = 9;      // one byte lane, one beat
    localparam int PAIR_W     = 18;     // two beats of one lane
    localparam int CHECK_W    = 5;      // hidden check bits per pair
    localparam int CODE_W     = 23;     // stored word per lane pair
    localparam int BEATS      = 4;      // beats per burst
    localparam int DEF_LANES  = 2;      // narrow configuration
    localparam int DEF_ADDR_W = 20;     // burst index of the narrow part

    // ------------------------------------------------------------------
    // power-up wait, in link clock cycles
    // ------------------------------------------------------------------
    localparam int IMPEDANCE_CYCLES = 163840;
    localparam int DLL_LOCK_CYCLES  = 65536;
    localparam int INIT_CNT_W       = 18;

    // ------------------------------------------------------------------
    // host divider: link clock is ref_clk / 4
    // ------------------------------------------------------------------
    localparam logic [1:0] PH_RISE = 2'h0;  // launch for the next K rise
    localparam logic [1:0] PH_FALL = 2'h2;  // launch for the next K# rise
    localparam logic [1:0] PH_LAST = 2'h3;  // last ref cycle of a link cycle
    localparam logic [2:0] WS_IDLE  = 3'h0;
    localparam logic [2:0] WS_ARMED = 3'h1;
    localparam logic [2:0] WS_BEAT0 = 3'h2;
    localparam logic [2:0] WS_BEAT3 = 3'h5;

    typedef enum logic [1:0] {
        QDB_NONE  = 2'b00,
        QDB_READ  = 2'b01,
        QDB_WRITE = 2'b10
    } qdb_cmd_e;

endpackage

// ---- design/qdb_if.sv ----
`timescale 1ns/1ps

// pins between the memory controller and the burst memory
interface qdb_if #(
    parameter int AddrW = qdb_pkg::DEF_ADDR_W,
    parameter int Lanes = qdb_pkg::DEF_LANES
);
    localparam int DataW = Lanes * qdb_pkg::LANE_W;

    logic             linkClk;
    logic             linkClkN;
    logic [AddrW-1:0] syncAddressIn;
    logic             readSel_n;
    logic             writeSel_n;
    logic [Lanes-1:0] byteLaneMask_n;
    logic [DataW-1:0] writeDataIn;
    logic [DataW-1:0] readDataOut;
    logic             outputValid;
    logic             dllDisable_n;

    modport dev (
        input  linkClk, linkClkN, syncAddressIn, readSel_n, writeSel_n,
        input  byteLaneMask_n, writeDataIn, dllDisable_n,
        output readDataOut, outputValid
    );

    modport ctrl (
        output linkClk, linkClkN, syncAddressIn, readSel_n, writeSel_n,
        output byteLaneMask_n, writeDataIn, dllDisable_n,
        input  readDataOut, outputValid
    );
endinterface

// ---- design/qdb_mem_dev.sv ----
`timescale 1ns/1ps

// Functional notes
// RULE_01: address and selects sampled every K rise
// RULE_02: both selects high means deselect
// RULE_03: read select low starts a read
// RULE_04: read select ignored right after a read
// RULE_05: read select high is a read deselect
// RULE_06: write low with read high starts write
// RULE_07: write select ignored right after a write
// RULE_08: write beats on K, K#, K, K#
// RULE_09: one address carries a four-beat burst
// RULE_10: lane masks sampled with each data beat
// RULE_11: masked lane beat leaves memory unchanged
// RULE_12: any mask pattern allowed on any beat
// RULE_13: half write turns correction off for good
// RULE_14: 5 check bits guard each 18-bit pair
// RULE_15: correct single errors only, no flagging
// RULE_16: controller waits out impedance and loop lock
// RULE_17: loop-disable low turns the loop off
// RULE_18: mask pairs give full, half or abort
// RULE_19: controller uses only full or abort pairs; the host passes cmdWrMask_n through unchecked
// RULE_20: read beats start two cycles after command
// RULE_21: reads return corrected data while enabled
module qdb_mem_dev #(
    parameter int AddrW = qdb_pkg::DEF_ADDR_W,
    parameter int Lanes = qdb_pkg::DEF_LANES
) (
    qdb_if.dev  link,
    input  wire logic rst_n,
    output logic      eccEnabled,
    output logic      dllActive
);
    import qdb_pkg::*;

    localparam int DataW = Lanes * LANE_W;
    localparam int MemW  = Lanes * 2 * CODE_W;

    // ------------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------------
    if (Lanes < 1 || Lanes > 4) begin : gLaneChk
        $error("qdb_mem_dev: Lanes must be 1 to 4");
    end
    if (AddrW < 1 || AddrW > 24) begin : gAddrChk
        $error("qdb_mem_dev: AddrW must be 1 to 24");
    end
    if ($bits(link.syncAddressIn) != AddrW) begin : gBusChk
        $error("qdb_mem_dev: interface address width differs");
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    // K domain: command decode, write pipe, read pipe, sticky ecc flag, loop state
    typedef struct packed {
        qdb_cmd_e                     prevCmd;
        logic [2:0]                   wrStage;
        logic [2:0][AddrW-1:0]        wrAddr;
        logic [2:0][DataW-1:0]        beat;
        logic [2:0][Lanes-1:0]        mask;
        logic                         rdLoad;
        logic [AddrW-1:0]             rdAddr;
        logic [1:0]                   rdStage;
        logic [BEATS-1:0][DataW-1:0]  rdWords;
        logic [DataW-1:0]             qRise;
        logic [DataW-1:0]             qFallPend;
        logic                         oeRise;
        logic                         eccOff;
        logic                         dllOn;
    } qdb_dev_s;

    // K# domain: odd write beats in, odd read beats out
    typedef struct packed {
        logic [DataW-1:0] dFall;
        logic [Lanes-1:0] mFall;
        logic [DataW-1:0] qFall;
        logic             oeFall;
    } qdb_fall_s;

    qdb_dev_s                s_r;
    qdb_dev_s                s_nxt;
    qdb_fall_s               f_r;
    qdb_fall_s               f_nxt;
    logic [MemW-1:0]         mem [2**AddrW];
    logic                    isRead;
    logic                    isWrite;
    logic [MemW-1:0]         oldWord;
    logic [MemW-1:0]         memWord;
    logic [MemW-1:0]         rdCode;
    logic                    halfSeen;
    logic [BEATS-1:0][DataW-1:0] wb;
    logic [BEATS-1:0][Lanes-1:0] wm;
    logic [BEATS-1:0][DataW-1:0] rdDec;

    // ------------------------------------------------------------------
    // hamming code over 23 positions, check bits at powers of two
    // ------------------------------------------------------------------
    function automatic logic isDataPos(input int p);
        return (p & (p - 1)) != 0;
    endfunction

    function automatic logic [CHECK_W-1:0] hamSyn(
        input logic [CODE_W-1:0] c
    );
        logic [CHECK_W-1:0] x;
        x = '0;
        for (int p = 1; p <= CODE_W; p++) begin
            if (c[p-1]) begin
                x = x ^ CHECK_W'(p);
            end
        end
        return x;
    endfunction

    function automatic logic [CODE_W-1:0] hamEnc(
        input logic [PAIR_W-1:0] d
    );
        logic [CODE_W-1:0]  c;
        logic [CHECK_W-1:0] x;
        int                 k;
        c = '0;
        k = 0;
        for (int p = 1; p <= CODE_W; p++) begin
            if (isDataPos(p)) begin
                c[p-1] = d[k];
                k++;
            end
        end
        x = hamSyn(c);
        for (int j = 0; j < CHECK_W; j++) begin
            c[(1 << j) - 1] = x[j];  // RULE_14
        end
        return c;
    endfunction

    // a double error yields a wrong flip or none, and no flag
    function automatic logic [PAIR_W-1:0] hamDec(
        input logic [CODE_W-1:0] c,
        input logic              fix
    );
        logic [CODE_W-1:0]  w;
        logic [CHECK_W-1:0] x;
        logic [PAIR_W-1:0]  d;
        int                 k;
        w = c;
        d = '0;
        k = 0;
        x = hamSyn(c);
        if (fix && x != '0 && int'(x) <= CODE_W) begin
            w[int'(x)-1] = ~w[int'(x)-1];  // RULE_15 RULE_21
        end
        for (int p = 1; p <= CODE_W; p++) begin
            if (isDataPos(p)) begin
                d[k] = w[p-1];
                k++;
            end
        end
        return d;
    endfunction

    // ------------------------------------------------------------------
    // burst commit: merge, mask and encode every lane pair that is not an abort
    // ------------------------------------------------------------------
    always_comb begin
        logic [PAIR_W-1:0] old;
        logic [LANE_W-1:0] lo;
        logic [LANE_W-1:0] hi;
        int                idx;
        old      = '0;
        lo       = '0;
        hi       = '0;
        idx      = 0;
        wb       = {f_r.dFall, s_r.beat[2], s_r.beat[1], s_r.beat[0]};
        wm       = {f_r.mFall, s_r.mask[2], s_r.mask[1], s_r.mask[0]};
        oldWord  = mem[s_r.wrAddr[2]];
        memWord  = oldWord;
        halfSeen = 1'b0;
        for (int l = 0; l < Lanes; l++) begin
            for (int p = 0; p < 2; p++) begin
                idx = l * 2 + p;
                old = hamDec(oldWord[idx*CODE_W +: CODE_W], ~s_r.eccOff);
                lo  = wm[2*p][l] ? old[LANE_W-1:0]
                                 : wb[2*p][l*LANE_W +: LANE_W];  // RULE_11
                hi  = wm[2*p+1][l] ? old[PAIR_W-1:LANE_W]
                                   : wb[2*p+1][l*LANE_W +: LANE_W];
                // both masks high is an abort: stored code kept bit for bit
                if (!(wm[2*p][l] && wm[2*p+1][l])) begin
                    memWord[idx*CODE_W +: CODE_W] = hamEnc({hi, lo}); // RULE_18
                end
                if (wm[2*p][l] ^ wm[2*p+1][l]) begin
                    halfSeen = 1'b1;  // RULE_13 RULE_12
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // array read for a launched read, with bypass of a same-edge commit
    // ------------------------------------------------------------------
    always_comb begin
        int idx;
        logic [PAIR_W-1:0] pr;
        idx = 0;
        pr  = '0;
        if (s_r.wrStage[2] && s_r.wrAddr[2] == s_r.rdAddr) begin
            rdCode = memWord;
        end else begin
            rdCode = mem[s_r.rdAddr];
        end
        rdDec = '0;
        for (int b = 0; b < BEATS; b++) begin
            for (int l = 0; l < Lanes; l++) begin
                idx = l * 2 + b / 2;
                pr  = hamDec(rdCode[idx*CODE_W +: CODE_W], ~s_r.eccOff);
                rdDec[b][l*LANE_W +: LANE_W] = (b % 2 == 1) ?
                    pr[PAIR_W-1:LANE_W] : pr[LANE_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // command decode and pipelines, K domain
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt   = s_r;
        isRead  = !link.readSel_n && s_r.prevCmd != QDB_READ; // RULE_03 RULE_04
        isWrite = !link.writeSel_n && !isRead                  // RULE_06
                  && s_r.prevCmd != QDB_WRITE;                 // RULE_07
        // both selects high, or only ignored selects, loads a deselect
        if (isRead) begin
            s_nxt.prevCmd = QDB_READ;
        end else if (isWrite) begin
            s_nxt.prevCmd = QDB_WRITE;
        end else begin
            s_nxt.prevCmd = QDB_NONE;  // RULE_02 RULE_05
        end

        // write pipe: A takes beat 0, B beats 1 and 2, C commits
        s_nxt.wrStage = {s_r.wrStage[1:0], isWrite};  // RULE_09
        if (isWrite) begin
            s_nxt.wrAddr[0] = link.syncAddressIn;  // RULE_01
        end
        if (s_r.wrStage[0]) begin
            s_nxt.beat[0]   = link.writeDataIn;  // RULE_08
            s_nxt.mask[0]   = link.byteLaneMask_n;  // RULE_10
            s_nxt.wrAddr[1] = s_r.wrAddr[0];
        end
        if (s_r.wrStage[1]) begin
            s_nxt.beat[1]   = f_r.dFall;
            s_nxt.mask[1]   = f_r.mFall;
            s_nxt.beat[2]   = link.writeDataIn;
            s_nxt.mask[2]   = link.byteLaneMask_n;
            s_nxt.wrAddr[2] = s_r.wrAddr[1];
        end
        s_nxt.eccOff = s_r.eccOff | (s_r.wrStage[2] & halfSeen); // RULE_13

        // read pipe: load words, then beats 0/1 and 2/3
        s_nxt.rdLoad  = isRead;
        s_nxt.rdStage = {s_r.rdStage[0], s_r.rdLoad};
        if (isRead) begin
            s_nxt.rdAddr = link.syncAddressIn;
        end
        if (s_r.rdLoad) begin
            s_nxt.rdWords = rdDec;  // RULE_21
        end
        if (s_r.rdStage[0]) begin
            s_nxt.qRise     = s_r.rdWords[0];  // RULE_20
            s_nxt.qFallPend = s_r.rdWords[1];
            s_nxt.oeRise    = 1'b1;
        end else if (s_r.rdStage[1]) begin
            s_nxt.qRise     = s_r.rdWords[2];
            s_nxt.qFallPend = s_r.rdWords[3];
            s_nxt.oeRise    = 1'b1;
        end else begin
            s_nxt.qRise     = '0;
            s_nxt.qFallPend = '0;
            s_nxt.oeRise    = 1'b0;
        end
        s_nxt.dllOn = link.dllDisable_n;  // RULE_17

        // power-on reset: also the only way to re-arm correction
        if (!rst_n) begin
            s_nxt = '0;
        end
    end

    always_ff @(posedge link.linkClk) begin
        s_r <= s_nxt;
    end

    // array write of a committed burst
    always_ff @(posedge link.linkClk) begin
        if (s_r.wrStage[2]) begin
            mem[s_r.wrAddr[2]] <= memWord;
        end
    end

    // ------------------------------------------------------------------
    // K# domain: half a cycle after K, source synchronous by design
    // ------------------------------------------------------------------
    // no reset here: every field is reloaded on each K# rise
    always_comb begin
        f_nxt.dFall  = link.writeDataIn;  // RULE_08
        f_nxt.mFall  = link.byteLaneMask_n;  // RULE_10
        f_nxt.qFall  = s_r.qFallPend;
        f_nxt.oeFall = s_r.oeRise;
    end

    always_ff @(posedge link.linkClkN) begin
        f_r <= f_nxt;
    end

    // ------------------------------------------------------------------
    // outputs: ddr mux, K high shows the K beat, K low the K# beat
    // ------------------------------------------------------------------
    assign link.readDataOut = link.linkClk ? s_r.qRise  : f_r.qFall;
    assign link.outputValid = link.linkClk ? s_r.oeRise : f_r.oeFall;
    assign eccEnabled       = ~s_r.eccOff;
    assign dllActive        = s_r.dllOn;

endmodule

// ---- design/qdb_ctrl_host.sv ----
`timescale 1ns/1ps

// memory controller end: makes the link clock, spaces commands,
// streams burst data and gathers read bursts
module qdb_ctrl_host #(
    parameter int AddrW           = qdb_pkg::DEF_ADDR_W,
    parameter int Lanes           = qdb_pkg::DEF_LANES,
    parameter int ImpedanceCycles = qdb_pkg::IMPEDANCE_CYCLES,
    parameter int DllLockCycles   = qdb_pkg::DLL_LOCK_CYCLES
) (
    input  wire logic                        ref_clk,
    input  wire logic                        rst_n,
    qdb_if.ctrl                              link,
    input  wire logic                        cmdValid,
    input  wire logic                        cmdRead,
    input  wire logic [AddrW-1:0]            cmdAddr,
    input  wire logic [4*Lanes*9-1:0]        cmdWrData,
    input  wire logic [4*Lanes-1:0]          cmdWrMask_n,
    input  wire logic                        dllEnable,
    output logic                             cmdReady,
    output logic                             rdValid,
    output logic [4*Lanes*9-1:0]             rdData,
    output logic                             initDone
);
    import qdb_pkg::*;

    localparam int DataW   = Lanes * LANE_W;
    localparam int InitEnd = ImpedanceCycles + DllLockCycles;

    if (InitEnd < 1 || InitEnd >= 2**INIT_CNT_W) begin : gInitChk
        $error("qdb_ctrl_host: power-up wait out of counter range");
    end
    if (Lanes < 1 || Lanes > 4) begin : gLaneChk
        $error("qdb_ctrl_host: Lanes must be 1 to 4");
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0]                   cnt;
        logic                         linkClk;
        logic [INIT_CNT_W-1:0]        initCnt;
        logic                         initDone;
        logic [AddrW-1:0]             addr;
        logic                         rdSelN;
        logic                         wrSelN;
        logic                         dllOffN;
        logic [DataW-1:0]             dOut;
        logic [Lanes-1:0]             mOut;
        qdb_cmd_e                     lastCmd;
        logic [2:0]                   wrStep;
        logic [BEATS-1:0][DataW-1:0]  wrBuf;
        logic [BEATS-1:0][Lanes-1:0]  wrMask;
        logic [DataW-1:0]             s1Data;
        logic [DataW-1:0]             s2Data;
        logic                         s1Vld;
        logic                         s2Vld;
        logic [BEATS-1:0][DataW-1:0]  rdBuf;
        logic [1:0]                   rdCnt;
        logic                         rdValid;
    } qdb_host_s;

    qdb_host_s  s_r;
    qdb_host_s  s_nxt;
    logic [1:0] beatIdx;
    logic       beatPhase;

    // ------------------------------------------------------------------
    // accept: one command per link cycle, never two alike in a row
    // ------------------------------------------------------------------
    assign beatPhase = (s_r.cnt == PH_RISE) || (s_r.cnt == PH_FALL);
    assign beatIdx   = 2'(s_r.wrStep - WS_BEAT0);
    assign cmdReady  = s_r.initDone && s_r.cnt == PH_RISE &&
                       (cmdRead ? s_r.lastCmd != QDB_READ      // RULE_04
                                : (s_r.lastCmd != QDB_WRITE    // RULE_07
                                   && s_r.wrStep == WS_IDLE));

    always_comb begin
        s_nxt         = s_r;
        s_nxt.rdValid = 1'b0;
        s_nxt.cnt     = s_r.cnt + 2'h1;

        // power-up wait counted in link cycles
        if (s_r.cnt == PH_LAST && !s_r.initDone) begin
            s_nxt.initCnt = s_r.initCnt + INIT_CNT_W'(1);
            if (s_r.initCnt == INIT_CNT_W'(InitEnd - 1)) begin
                s_nxt.initDone = 1'b1;  // RULE_16
            end
        end

        // burst data: beats 0,2 before K rise, 1,3 before K# rise
        if (beatPhase) begin
            if (s_r.wrStep >= WS_BEAT0) begin
                s_nxt.dOut   = s_r.wrBuf[beatIdx];  // RULE_08
                s_nxt.mOut   = s_r.wrMask[beatIdx];  // RULE_10
                s_nxt.wrStep = (s_r.wrStep == WS_BEAT3) ? WS_IDLE
                                                        : s_r.wrStep + 3'h1;
            end else begin
                s_nxt.mOut = '1;
                if (s_r.wrStep == WS_ARMED && s_r.cnt == PH_FALL) begin
                    s_nxt.wrStep = WS_BEAT0;
                end
            end
        end

        // command slot, launched one ref cycle (a quarter link cycle) before K rise
        if (s_r.cnt == PH_RISE) begin
            s_nxt.rdSelN  = 1'b1;
            s_nxt.wrSelN  = 1'b1;
            s_nxt.lastCmd = QDB_NONE;
            // loop control moves only here, never on a K or K# edge
            s_nxt.dllOffN = dllEnable;  // RULE_17
            if (cmdValid && cmdReady) begin
                s_nxt.addr = cmdAddr;  // RULE_01
                if (cmdRead) begin
                    s_nxt.rdSelN  = 1'b0;
                    s_nxt.lastCmd = QDB_READ;
                end else begin
                    s_nxt.wrSelN  = 1'b0;
                    s_nxt.lastCmd = QDB_WRITE;
                    s_nxt.wrBuf   = cmdWrData;
                    s_nxt.wrMask  = cmdWrMask_n;  // RULE_19
                    s_nxt.wrStep  = WS_ARMED;
                end
            end
        end

        // read beats: two flops, then sampled mid beat
        s_nxt.s1Data = link.readDataOut;
        s_nxt.s2Data = s_r.s1Data;
        s_nxt.s1Vld  = link.outputValid;
        s_nxt.s2Vld  = s_r.s1Vld;
        if (beatPhase && s_r.s2Vld) begin
            s_nxt.rdBuf[s_r.rdCnt] = s_r.s2Data;  // RULE_20
            s_nxt.rdCnt            = s_r.rdCnt + 2'h1;
            if (s_r.rdCnt == 2'h3) begin
                s_nxt.rdValid = 1'b1;
            end
        end

        // divider keeps running in reset so the device sees edges
        if (!rst_n) begin
            s_nxt = '0;
            if (s_r.cnt == 2'h1) begin
                s_nxt.cnt = 2'h2;
            end else begin
                s_nxt.cnt = 2'h1;
            end
            s_nxt.rdSelN  = 1'b1;
            s_nxt.wrSelN  = 1'b1;
            s_nxt.mOut    = '1;
        end
        s_nxt.linkClk = s_nxt.cnt[1];
    end

    always_ff @(posedge ref_clk) begin
        s_r <= s_nxt;
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign link.linkClk        = s_r.linkClk;
    assign link.linkClkN       = ~s_r.linkClk;
    assign link.syncAddressIn  = s_r.addr;
    assign link.readSel_n      = s_r.rdSelN;
    assign link.writeSel_n     = s_r.wrSelN;
    assign link.byteLaneMask_n = s_r.mOut;
    assign link.writeDataIn    = s_r.dOut;
    assign link.dllDisable_n   = s_r.dllOffN;
    assign rdValid             = s_r.rdValid;
    assign rdData              = s_r.rdBuf;
    assign initDone            = s_r.initDone;

endmodule

// ---- bench/qdb_assertions.sv ----
`timescale 1ns/1ps

// watches the pins between controller and memory in the link domain
module qdb_assertions (
    input wire logic        linkClk,
    input wire logic        rst_n,
    input wire logic        readSel_n,
    input wire logic        writeSel_n,
    input wire logic        outputValid,
    input wire logic [17:0] readDataOut,
    input wire logic        dllDisable_n,
    input wire logic        dllActive,
    input wire logic        eccEnabled
);
    logic rd, wr, prevRd_r, prevWr_r;

    // decode as the memory should; a repeat of the last kind is dropped
    assign rd = !readSel_n && !prevRd_r;
    assign wr = !rd && !writeSel_n && !prevWr_r;
    always_ff @(posedge linkClk) begin
        prevRd_r <= rst_n && rd;
        prevWr_r <= rst_n && wr;
    end

    default clocking @(posedge linkClk); endclocking
    default disable iff (!rst_n);

    a_read_answer: assert property (rd |-> ##3 outputValid)
        else $error("read burst missing");
    a_quiet_port: assert property (outputValid |->
        $past(rd, 3) || $past(rd, 4))
        else $error("beat without read");
    a_repeat_read: assert property (rd ##1 !readSel_n ##1
        readSel_n |-> ##3 !outputValid)
        else $error("second read taken");
    a_burst_length: assert property ($rose(outputValid) |=>
        outputValid)
        else $error("burst too short");
    a_idle_data: assert property (!outputValid |->
        readDataOut == '0)
        else $error("data while idle");
    a_ecc_cause: assert property ($fell(eccEnabled) |->
        $past(wr, 4) || $past(wr, 5))
        else $error("ecc off without write");
    a_ecc_sticky: assert property (!eccEnabled |=> !eccEnabled)
        else $error("ecc came back");
    a_dll_follow: assert property (dllActive ==
        $past(dllDisable_n))
        else $error("loop state wrong");

    cover property (rd);
    cover property (wr);
    cover property ($fell(eccEnabled));
endmodule

// ---- bench/test_quad_ddr_burst4_ecc_sram_port.sv ----
`timescale 1ns/1ps

module test_quad_ddr_burst4_ecc_sram_port;
    import qdb_pkg::*;
    localparam int BW = BEATS * DEF_LANES * LANE_W;
    logic          ref_clk = 1'b0;
    logic          rst_n = 1'b0;
    logic          cmdValid = 1'b0;
    logic          cmdRead = 1'b0;
    logic          dllEnable = 1'b1;
    logic [5:0]    cmdAddr = '0;
    logic [7:0]    cmdWrMask_n = 8'hFF;
    logic [BW-1:0] cmdWrData = '0, rdData, memExp [64], expQ [$];
    logic          cmdReady, rdValid, initDone, eccEnabled, dllActive;
    int            err_count = 0, n_checks = 0;

    qdb_if #(.AddrW(6)) link ();
    qdb_ctrl_host #(.AddrW(6), .ImpedanceCycles(8), .DllLockCycles(4))
        qdb_ctrl_host_inst (.ref_clk, .rst_n, .link, .cmdValid, .cmdRead,
        .cmdAddr, .cmdWrData, .cmdWrMask_n, .dllEnable, .cmdReady,
        .rdValid, .rdData, .initDone);
    qdb_mem_dev #(.AddrW(6)) qdb_mem_dev_inst (.link, .rst_n,
        .eccEnabled, .dllActive);
    qdb_assertions qdb_assertions_inst (.linkClk(link.linkClk), .rst_n,
        .readSel_n(link.readSel_n), .writeSel_n(link.writeSel_n),
        .outputValid(link.outputValid), .readDataOut(link.readDataOut),
        .dllDisable_n(link.dllDisable_n), .dllActive, .eccEnabled);

    // free-running reference clock
    always #2.5 ref_clk = ~ref_clk;

    task automatic check(string what, logic [BW-1:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // sampled on the falling edge so registered flags have settled
    task automatic wait_hi(ref logic s);
        for (int i = 0; i <= 500; i++) begin
            if (i == 500) begin
                err_count++;
                give_verdict();
            end
            @(negedge ref_clk);
            if (s === 1'b1) break;
        end
    endtask

    // one burst; the spacing after it keeps reads clear of the
    // write-to-read coherence gap
    task automatic send(bit rd, logic [5:0] a, logic [7:0] m);
        logic [BW-1:0] d;
        d = BW'({$urandom(), $urandom(), $urandom()});
        @(posedge ref_clk);
        cmdValid <= 1'b1;
        cmdRead <= rd;
        cmdAddr <= a;
        cmdWrData <= d;
        cmdWrMask_n <= m;
        wait_hi(cmdReady);
        @(posedge ref_clk);
        cmdValid <= 1'b0;
        if (rd)
            expQ.push_back(memExp[a]);
        else
            for (int k = 0; k < 8; k++)
                if (!m[k]) memExp[a][k*9+:9] = d[k*9+:9];
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    // each returned burst meets the oldest note
    always @(negedge ref_clk) begin
        if (rdValid === 1'b1)
            check("rdData", rdData, expQ.size() ? expQ.pop_front() : 'x);
    end

    initial begin
        void'($urandom(32'h79BB));
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        wait_hi(initDone);
        check("ecc", eccEnabled, 1'b1);
        check("dll", dllActive, 1'b1);
        for (int a = 0; a < 4; a++) send(0, a, 8'h00);
        for (int a = 0; a < 4; a++) send(1, a, 8'h00);
        $display("test full bursts done");
        send(0, 1, 8'hF5);
        send(1, 1, 8'h00);
        check("ecc", eccEnabled, 1'b1);
        $display("test abort pairs done");
        send(0, 3, 8'hFE);
        send(1, 3, 8'h00);
        check("ecc", eccEnabled, 1'b0);
        $display("test half write done");
        @(posedge ref_clk);
        dllEnable <= 1'b0;
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        check("dll", dllActive, 1'b0);
        for (int i = 0; i < 100 && expQ.size() != 0; i++) @(negedge ref_clk);
        check("pending", expQ.size(), 0);
        $display("test loop disable done");
        give_verdict();
    end
endmodule
